// File: inc/kpenc_consts.svh
// Purpose: timing counts and bit positions for the keypad encoder link
// Assumes: ref_clk at 20 MHz
// Notes:   counts derived from millisecond figures
`ifndef KPENC_CONSTS_SVH
`define KPENC_CONSTS_SVH
`define KPENC_CLK_HZ        20000000
// timer rate the bench hands the device, so a run stays short
`define KPENC_SIM_CLK_HZ    100000
`define KPENC_HZ_PER_KHZ    1000
`define KPENC_VALID_MS      20
`define KPENC_RELEASE_MS    50
`define KPENC_ROW_HI        5
`define KPENC_ROW_LO        3
`define KPENC_COL_HI        2
`define KPENC_COL_LO        0
`define KPENC_LOCK_BIT      7
`define KPENC_IO_ADDR       5'h06
`define KPENC_KEYFLAG_BIT   6
`define KPENC_KNOBFLAG_BIT  7
`define KPENC_CNT_W         21
`endif

// File: inc/kpenc_pkg.sv
// Purpose: shared types for the keypad encoder link
// Assumes: nothing
// Notes:   states are one-hot
package kpenc_pkg;
    typedef enum logic [3:0] {
        KPENC_IDLE    = 4'b0001,
        KPENC_VALID   = 4'b0010,
        KPENC_HELD    = 4'b0100,
        KPENC_RELEASE = 4'b1000
    } kpenc_state_type;
    typedef enum logic [2:0] {
        KPENC_H_IDLE = 3'b001,
        KPENC_H_READ = 3'b010,
        KPENC_H_CLR  = 3'b100
    } kpenc_hstate_type;
endpackage : kpenc_pkg

// File: inc/kpenc_if.sv
// Purpose: i/o bus link between keypad encoder and processor
// Assumes: single clock ref_clk
// Notes:   read data driven only in the cycle after a read strobe
`timescale 1ns/1ns
interface kpenc_if;
    logic [4:0] io_addr;
    logic [7:0] wr_data;
    logic       wr_strobe;
    logic       rd_strobe;
    logic       clr_strobe;
    logic [7:0] rd_data;
    logic       processor_request_n;
    modport dev (input io_addr, input wr_data, input wr_strobe, input rd_strobe, input clr_strobe,
                 output rd_data, output processor_request_n);
    modport proc (output io_addr, output wr_data, output wr_strobe, output rd_strobe, output clr_strobe,
                  input rd_data, input processor_request_n);
endinterface : kpenc_if

// File: logic/kpenc_device.sv
// Purpose: keypad priority encoders, validation timing and service request
// Assumes: row/col pins asynchronous, active low; knob flag from same-clock logic
// Notes:   one-shots realised as cycle counters
// Operation
// (RULE1) index encodes to inverted three-bit binary
// (RULE2) read buffer inverts six-bit code
// (RULE3) lowest active row and column win
// (RULE4) write strobe latches lockout from bit seven
// (RULE5) lockout disables row then column encoder
// (RULE6) any keypress asserts key-down
// (RULE7) processor reads code on request
// (RULE8) non-retriggerable twenty ms validation pulse
// (RULE9) key still held at end sets flag
// (RULE10) flag drives active-high key request
// (RULE11) request_n is nor of key, knob
// (RULE12) key flag read back inverted
// (RULE13) clear strobe clears flag, rearms detection
// (RULE14) lockout holds validation timer in reset
// (RULE15) each key grounds one row, one column
// (RULE16) rearm only after fifty ms all released
// (RULE17) pins synchronised, intervals as cycle counts
`timescale 1ns/1ns
`include "kpenc_consts.svh"
module kpenc_device
    import kpenc_pkg::*;
#(
    parameter int unsigned CLK_HZ = `KPENC_CLK_HZ
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    kpenc_if.dev      bus,
    input  wire logic [7:0] row_n,
    input  wire logic [7:0] col_n,
    input  wire logic knob_request_flag,
    output logic      key_request_flag,
    output logic      lockout
);
    function automatic logic [3:0] kpenc_prio(input logic [7:0] lines_n);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (!lines_n[i]) begin
                r = {1'b1, 3'(i)}; // [RULE3]
            end
        end
        return r;
    endfunction : kpenc_prio

    function automatic logic [2:0] kpenc_code_n(input logic [2:0] idx);
        return ~idx; // [RULE1]
    endfunction : kpenc_code_n

    function automatic logic [`KPENC_CNT_W-1:0] kpenc_ms_cycles(input int unsigned hz, input int unsigned ms);
        return `KPENC_CNT_W'((hz / `KPENC_HZ_PER_KHZ) * ms - 1); // [RULE17]
    endfunction : kpenc_ms_cycles

    function automatic logic kpenc_addr_hit(input logic [4:0] addr);
        return addr == `KPENC_IO_ADDR;
    endfunction : kpenc_addr_hit

    // loads are one below the span since the count ends at zero
    localparam logic [`KPENC_CNT_W-1:0] VALID_LOAD   = kpenc_ms_cycles(CLK_HZ, `KPENC_VALID_MS);
    localparam logic [`KPENC_CNT_W-1:0] RELEASE_LOAD = kpenc_ms_cycles(CLK_HZ, `KPENC_RELEASE_MS);

    logic [7:0]  row_m_q, row_s_q, col_m_q, col_s_q;
    logic        lock_q, lock_d;
    logic        flag_q, flag_d;
    logic [7:0]  rdat_q, rdat_d;
    kpenc_state_type st_q, st_d;
    logic [`KPENC_CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0]  row_e, col_e;
    logic        row_cascade;
    logic [2:0]  row_code_n, col_code_n;
    logic        key_down_n;
    logic        valid_hit;

    // two stages before any logic sees the matrix pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_m_q <= 8'hff;
            row_s_q <= 8'hff;
            col_m_q <= 8'hff;
            col_s_q <= 8'hff;
        end else begin
            row_m_q <= row_n; // [RULE17]
            row_s_q <= row_m_q;
            col_m_q <= col_n;
            col_s_q <= col_m_q;
        end
    end

    always_comb begin
        row_e = kpenc_prio(row_s_q); // [RULE15]
        col_e = kpenc_prio(col_s_q);
        // cascade high when locked out or no row grounded; it gates the column encoder
        row_cascade = lock_q | ~row_e[3]; // [RULE5]
        row_code_n = lock_q ? 3'h7 : kpenc_code_n(row_e[2:0]);
        col_code_n = (row_cascade | ~col_e[3]) ? 3'h7 : kpenc_code_n(col_e[2:0]);
        key_down_n = row_cascade | ~col_e[3]; // [RULE6]
    end

    // lockout latch: only a write strobe at the keypad address changes it
    always_comb begin
        lock_d = lock_q;
        if (bus.wr_strobe && kpenc_addr_hit(bus.io_addr)) begin
            lock_d = bus.wr_data[`KPENC_LOCK_BIT]; // [RULE4]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
        end
    end

    // key-down timer: validation pulse, held key, then release debounce
    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        valid_hit = 1'b0;
        case (st_q)
            KPENC_IDLE: begin
                if (!key_down_n) begin
                    st_d  = KPENC_VALID; // [RULE8]
                    cnt_d = VALID_LOAD;
                end
            end
            KPENC_VALID: begin
                // key-down ignored here so the pulse cannot retrigger
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1; // [RULE8]
                end else if (!key_down_n) begin
                    valid_hit = 1'b1; // [RULE9]
                    st_d      = KPENC_HELD;
                end else begin
                    st_d = KPENC_IDLE;
                end
            end
            KPENC_HELD: begin
                cnt_d = RELEASE_LOAD;
                // a key held past the clear must not raise a second request
                if (key_down_n && !flag_q) begin
                    st_d = KPENC_RELEASE; // [RULE13]
                end
            end
            KPENC_RELEASE: begin
                if (!key_down_n) begin
                    cnt_d = RELEASE_LOAD; // [RULE16]
                end else if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    st_d = KPENC_IDLE; // [RULE16]
                end
            end
            default: begin
                st_d = KPENC_IDLE;
            end
        endcase
        if (lock_q) begin
            st_d      = KPENC_IDLE; // [RULE14]
            cnt_d     = '0;
            valid_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= KPENC_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // request flag: a set in the cycle of a clear wins, so no keypress is lost
    always_comb begin
        flag_d = flag_q;
        if (bus.clr_strobe && kpenc_addr_hit(bus.io_addr)) begin
            flag_d = 1'b0; // [RULE13]
        end
        if (valid_hit) begin
            flag_d = 1'b1; // [RULE9]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // read buffer: zero outside a read, so no stale code lingers on the bus
    always_comb begin
        rdat_d = 8'h00;
        if (bus.rd_strobe && kpenc_addr_hit(bus.io_addr)) begin
            rdat_d[`KPENC_ROW_HI:`KPENC_ROW_LO] = ~row_code_n; // [RULE2]
            rdat_d[`KPENC_COL_HI:`KPENC_COL_LO] = ~col_code_n; // [RULE7]
            rdat_d[`KPENC_KEYFLAG_BIT]          = ~flag_q; // [RULE12]
            rdat_d[`KPENC_KNOBFLAG_BIT]         = ~knob_request_flag;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_q <= 8'h00;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    assign key_request_flag        = flag_q; // [RULE10]
    assign lockout                 = lock_q;
    assign bus.rd_data             = rdat_q;
    assign bus.processor_request_n = ~(flag_q | knob_request_flag); // [RULE11]
endmodule : kpenc_device

// File: logic/kpenc_host.sv
// Purpose: processor end: services key requests and sets lockout
// Assumes: device answers a read one cycle after the read strobe
// Notes:   issues read, then clear, per request
`timescale 1ns/1ns
`include "kpenc_consts.svh"
module kpenc_host
    import kpenc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    kpenc_if.proc     bus,
    input  wire logic lock_req,
    input  wire logic lock_value,
    output logic      key_valid,
    output logic [5:0] key_code,
    output logic      key_from_keypad
);
    kpenc_hstate_type st_q, st_d;
    logic [5:0] code_q, code_d;
    logic       valid_q, valid_d, src_q, src_d;
    logic       wr_q, wr_d, rd_q, rd_d, clr_q, clr_d;
    logic [7:0] wdat_q, wdat_d;

    always_comb begin
        st_d = st_q;
        code_d = code_q;
        src_d = src_q;
        valid_d = 1'b0;
        wr_d = 1'b0;
        rd_d = 1'b0;
        clr_d = 1'b0;
        wdat_d = wdat_q;
        case (st_q)
            KPENC_H_IDLE: begin
                if (lock_req) begin
                    wr_d = 1'b1; // [RULE4]
                    wdat_d = 8'h00;
                    wdat_d[`KPENC_LOCK_BIT] = lock_value;
                end else if (!bus.processor_request_n) begin
                    rd_d = 1'b1; // [RULE7]
                    st_d = KPENC_H_READ;
                end
            end
            KPENC_H_READ: begin
                if (!rd_q) begin
                    code_d = bus.rd_data[5:0];
                    src_d = ~bus.rd_data[`KPENC_KEYFLAG_BIT];
                    valid_d = 1'b1;
                    clr_d = 1'b1; // [RULE13]
                    st_d = KPENC_H_CLR;
                end
            end
            KPENC_H_CLR: begin
                // wait a cycle so the cleared request is seen before re-polling
                st_d = KPENC_H_IDLE;
            end
            default: st_d = KPENC_H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= KPENC_H_IDLE;
            code_q <= 6'h00;
            src_q <= 1'b0;
            valid_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            clr_q <= 1'b0;
            wdat_q <= 8'h00;
        end else begin
            st_q <= st_d;
            code_q <= code_d;
            src_q <= src_d;
            valid_q <= valid_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            clr_q <= clr_d;
            wdat_q <= wdat_d;
        end
    end

    assign bus.io_addr    = `KPENC_IO_ADDR;
    assign bus.wr_data    = wdat_q;
    assign bus.wr_strobe  = wr_q;
    assign bus.rd_strobe  = rd_q;
    assign bus.clr_strobe = clr_q;
    assign key_valid       = valid_q;
    assign key_code        = code_q;
    assign key_from_keypad = src_q;
endmodule : kpenc_host

// File: tb/kpenc_assertions.sv
// Purpose: bus checks for the keypad encoder link
// Assumes: one clock, async active-low reset
// Notes:   sees only the interface signals
`timescale 1ns/1ns
module kpenc_assertions (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [4:0] io_addr,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic       clr_strobe,
    input wire logic [7:0] rd_data,
    input wire logic       processor_request_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE_ZERO: assert property (!rd_strobe |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    AST_REQ_FLAGS: assert property (rd_strobe && !processor_request_n |=> rd_data[7:6] != 2'b11)
        else $error("no source flagged in a requested read");
    AST_STROBE_ADDR: assert property ((rd_strobe || wr_strobe || clr_strobe) |-> io_addr == 5'h06)
        else $error("strobe at wrong address");
    AST_RD_PULSE: assert property (rd_strobe |=> !rd_strobe)
        else $error("read strobe too long");
    AST_WR_PULSE: assert property ($rose(wr_strobe) |=> !wr_strobe)
        else $error("write strobe too long");
    AST_CLR_PULSE: assert property (clr_strobe |=> !clr_strobe ##1 !clr_strobe)
        else $error("clear strobe too long");
    AST_READ_THEN_CLEAR: assert property (rd_strobe |-> ##2 clr_strobe)
        else $error("read not followed by clear");
    AST_CLEAR_AFTER_READ: assert property (clr_strobe |-> $past(rd_strobe, 2))
        else $error("clear without read");
    COV_SERVICE: cover property (rd_strobe && !processor_request_n ##1 !rd_data[6] ##1 clr_strobe);
    COV_WRITE: cover property (wr_strobe);
    COV_KNOB: cover property (rd_strobe ##1 !rd_data[7]);
endmodule : kpenc_assertions

// File: tb/kpenc_tb_top.sv
// Purpose: self-checking bench, device and host joined by the bus
// Assumes: 20 MHz clock, device timers scaled through its clock-rate parameter
// Notes:   scaled timers keep the millisecond figures within a short run
`timescale 1ns/1ns
`include "kpenc_consts.svh"
module kpenc_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  row_n = 8'hff;
    logic [7:0]  col_n = 8'hff;
    logic        knob_request_flag = 1'b0;
    logic        lock_req = 1'b0;
    logic        lock_value = 1'b0;
    logic        key_request_flag, lockout, key_valid, key_from_keypad;
    logic [5:0]  key_code;
    logic [16:0] lfsr = 17'h10be5;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          n;
    kpenc_if bus_if ();
    always #25 ref_clk = ~ref_clk;
    kpenc_device #(.CLK_HZ(`KPENC_SIM_CLK_HZ)) kpenc_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if.dev),
        .row_n(row_n),
        .col_n(col_n), .knob_request_flag(knob_request_flag), .key_request_flag(key_request_flag), .lockout(lockout));
    kpenc_host kpenc_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if.proc), .lock_req(lock_req),
        .lock_value(lock_value), .key_valid(key_valid), .key_code(key_code), .key_from_keypad(key_from_keypad));
    kpenc_assertions kpenc_assertions_inst (.ref_clk(ref_clk), .rst_n(rst_n), .io_addr(bus_if.io_addr),
        .wr_strobe(bus_if.wr_strobe), .rd_strobe(bus_if.rd_strobe), .clr_strobe(bus_if.clr_strobe),
        .rd_data(bus_if.rd_data), .processor_request_n(bus_if.processor_request_n));
    function automatic logic [16:0] lfsr_next(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr_next
    // milliseconds to cycles at the rate the device is given
    function automatic int ms_cycles(input int ms);
        return (`KPENC_SIM_CLK_HZ / `KPENC_HZ_PER_KHZ) * ms;
    endfunction : ms_cycles
    localparam int VALID_CYC   = ms_cycles(`KPENC_VALID_MS);
    localparam int RELEASE_CYC = ms_cycles(`KPENC_RELEASE_MS);
    function automatic logic [7:0] idx_lines_n(input logic [2:0] idx);
        return ~(8'h01 << idx);
    endfunction : idx_lines_n
    // lowest active index wins, as the encoders must report
    function automatic logic [2:0] lowest_idx(input logic [7:0] v);
        lowest_idx = 3'h0;
        for (int i = 7; i >= 0; i--) if (v[i]) lowest_idx = i[2:0];
    endfunction : lowest_idx
    task automatic check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic cycles(input int c);
        repeat (c) @(negedge ref_clk);
    endtask : cycles
    task automatic set_lock(input logic v);
        lock_value = v;
        lock_req = 1'b1;
        cycles(1);
        lock_req = 1'b0;
        cycles(4);
        check(lockout === v, "lockout bit wrong");
    endtask : set_lock
    task automatic wait_key(input int start);
        n = start;
        while (key_valid !== 1'b1 && n < VALID_CYC + 100) begin
            cycles(1);
            n++;
        end
    endtask : wait_key
    // span covers every scenario with ample margin
    initial begin
        cycles(16 + 8 * (VALID_CYC + RELEASE_CYC));
        mismatches++;
        test_done();
    end
    initial begin
        logic [7:0] rows;
        logic [7:0] cols;
        logic [2:0] r_idx;
        logic [2:0] c_idx;
        cycles(16);
        rst_n = 1'b1;
        cycles(2);
        for (int i = 0; i < 32; i++) begin
            lfsr = lfsr_next(lfsr);
            knob_request_flag = lfsr[0];
            #1;
            check(bus_if.processor_request_n === ~lfsr[0], "request not nor of flags");
            cycles(8);
        end
        knob_request_flag = 1'b0;
        cycles(20);
        row_n = 8'hf7;
        col_n = 8'hdf;
        cycles(200);
        row_n = 8'hff;
        cycles(VALID_CYC + 100);
        check(key_request_flag === 1'b0, "short press accepted");
        set_lock(1'b1);
        row_n = 8'hf7;
        cycles(VALID_CYC + 100);
        check(key_request_flag === 1'b0 && bus_if.processor_request_n === 1'b1, "press under lockout");
        row_n = 8'hff;
        set_lock(1'b0);
        lfsr = lfsr_next(lfsr);
        rows = 8'h08 | {lfsr[4:0], 3'h0};
        cols = 8'h20 | {lfsr[9:8], 6'h00};
        row_n = ~rows;
        col_n = ~cols;
        // a bounce mid-pulse must not restart the validation time
        cycles(VALID_CYC / 2);
        row_n = 8'hff;
        cycles(10);
        row_n = ~rows;
        wait_key(VALID_CYC / 2 + 10);
        check(n >= VALID_CYC && n <= VALID_CYC + 10, "validation time wrong");
        check(key_request_flag === 1'b1, "key flag not set");
        check(key_code === {lowest_idx(rows), lowest_idx(cols)}, "key code wrong");
        check(key_from_keypad === 1'b1, "request source wrong");
        cycles(2);
        check(key_request_flag === 1'b0 && bus_if.processor_request_n === 1'b1, "flag not cleared");
        row_n = 8'hff;
        col_n = 8'hff;
        // a press inside the release time stays unseen however long it lasts
        cycles(RELEASE_CYC / 2);
        lfsr = lfsr_next(lfsr);
        r_idx = lfsr[2:0];
        c_idx = lfsr[5:3];
        row_n = idx_lines_n(r_idx);
        col_n = idx_lines_n(c_idx);
        cycles(VALID_CYC + 100);
        check(key_request_flag === 1'b0 && bus_if.processor_request_n === 1'b1, "press seen in release time");
        row_n = 8'hff;
        col_n = 8'hff;
        cycles(RELEASE_CYC + 10);
        row_n = idx_lines_n(r_idx);
        col_n = idx_lines_n(c_idx);
        wait_key(0);
        check(n >= VALID_CYC && n <= VALID_CYC + 10, "no rearm after release time");
        check(key_code === {r_idx, c_idx}, "single key code wrong");
        check(key_from_keypad === 1'b1, "second request source wrong");
        row_n = 8'hff;
        col_n = 8'hff;
        cycles(10);
        test_done();
    end
endmodule : kpenc_tb_top
